/* hw/ser_status.sv */
`timescale 1ns/1ps
module ser_status
  import ser_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic power_off,
  input wire ser_req_s req,
  input wire logic clear_status,
  input wire logic psc_wr,
  input wire logic psc_val,
  input wire logic stb_query,
  input wire logic serial_poll_done,
  input wire logic [7:0] std_events_in,
  input wire logic overvoltage_trip,
  input wire logic power_interrupted,
  input wire logic query_error,
  input wire logic remote_to_local,
  input wire logic signal_one_active,
  input wire logic signal_two_active,
  input wire logic signal_three_active,
  input wire logic sequence_running,
  input wire logic sequence_done,
  input wire logic sequence_error,
  input wire logic trigger_input_one,
  input wire logic trigger_input_two,
  input wire logic trig_one_off,
  input wire logic trig_two_off,
  input wire logic selftest_busy,
  input wire logic selftest_error,
  input wire logic output_data_ready,
  input wire logic [7:0] rise_en_a,
  input wire logic [7:0] fall_en_a,
  input wire logic [7:0] rise_en_b,
  input wire logic [7:0] fall_en_b,
  output logic [7:0] rd_data,
  output logic [7:0] condition_reg_a,
  output logic [7:0] condition_reg_b,
  output logic [7:0] status_byte,
  output logic [7:0] poll_byte,
  output logic psc_flag,
  output logic service_request,
  output logic parallel_poll
);
  logic [7:0] pin_s1_reg, pin_s2_reg;
  logic [7:0] cra_next, crb_next;
  logic [7:0] event_reg_a, event_reg_b, event_reg_c, std_reg;
  logic [7:0] event_mask_a, event_mask_b, event_mask_c, std_mask, sre_mask, pre_mask;
  logic rqs_reg, mss_d;
  logic ov_s, pi_s, qe_s, rl_s, s1_s, s2_s, s3_s, sr_s, sd_s, se_s, t1_s, t2_s, tb_s, te_s, mav_s, t1o_s, t2o_s;
  logic [7:0] stb_next;
  logic sum_a, sum_b, sum_c, sum_std, mss, rqs_next;
  logic clr_a, clr_b, clr_c, clr_std;
  logic [7:0] rd_next;
  logic [7:0] ccr_c;
  logic [7:0] std_hit;

  function automatic logic group_sum(input logic [7:0] src, input logic [7:0] msk);
    group_sum = |(src & msk);
  endfunction

  // two-stage sync of external status inputs
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end
    else
    begin
      pin_s1_reg <= {overvoltage_trip, power_interrupted, query_error, remote_to_local,
        signal_one_active, signal_two_active, signal_three_active, trigger_input_one};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  logic [8:0] pin2_s1_reg, pin2_s2_reg;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin2_s1_reg <= '0;
      pin2_s2_reg <= '0;
    end
    else
    begin
      pin2_s1_reg <= {trigger_input_two, sequence_running, sequence_done, sequence_error,
        selftest_busy, selftest_error, output_data_ready, trig_one_off, trig_two_off};
      pin2_s2_reg <= pin2_s1_reg;
    end
  end
  assign {ov_s, pi_s, qe_s, rl_s, s1_s, s2_s, s3_s, t1_s} = pin_s2_reg;
  assign {t2_s, sr_s, sd_s, se_s, tb_s, te_s, mav_s, t1o_s, t2o_s} = pin2_s2_reg;

  // condition registers: live mirror only
  assign cra_next = {ov_s, pi_s, qe_s, rl_s, s1_s, s2_s, s3_s, s1_s | s2_s | s3_s};
  assign crb_next = {sr_s, sd_s, se_s, t1_s & ~t1o_s, t2_s & ~t2o_s, tb_s, te_s, 1'b0};
  assign ccr_c = {mav_s, 7'h00};

  // query side effects
  // a mask read (data bit 7 set) must leave the event register alone
  assign clr_std = clear_status | (req.rd && !req.data[7] && req.sel == SER_SEL_STD);
  assign clr_a = clear_status | (req.rd && !req.data[7] && req.sel == SER_SEL_A);
  assign clr_b = clear_status | (req.rd && !req.data[7] && req.sel == SER_SEL_B);
  assign clr_c = clear_status | (req.rd && !req.data[7] && req.sel == SER_SEL_C);
  assign std_hit = std_events_in;

  ser_edge_reg #(.W(8)) u_ea (.sys_clk(sys_clk), .rst(rst), .cond(cra_next), .rise_en(rise_en_a),
    .fall_en(fall_en_a), .clr(clr_a), .events(event_reg_a));
  ser_edge_reg #(.W(8)) u_eb (.sys_clk(sys_clk), .rst(rst), .cond(crb_next), .rise_en(rise_en_b),
    .fall_en(fall_en_b), .clr(clr_b), .events(event_reg_b));
  ser_edge_reg #(.W(8)) u_ec (.sys_clk(sys_clk), .rst(rst), .cond(ccr_c), .rise_en(8'hFF),
    .fall_en(8'h00), .clr(clr_c), .events(event_reg_c));

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      std_reg <= '0;
    else
      std_reg <= (clr_std ? 8'h00 : std_reg) | std_hit;
  end

  // group summaries and status byte
  assign sum_a = group_sum(event_reg_a, event_mask_a);
  assign sum_b = group_sum(event_reg_b, event_mask_b);
  assign sum_c = group_sum(event_reg_c, event_mask_c);
  assign sum_std = group_sum(std_reg, std_mask);
  assign mss = group_sum({2'b00, sum_std, mav_s, sum_c, sum_b, sum_a, 1'b0}, sre_mask & 8'h3E);
  assign stb_next = {1'b0, mss, sum_std, mav_s, sum_c, sum_b, sum_a, 1'b0};
  // request state latches on a rising summary and drops after poll or clear
  assign rqs_next = (serial_poll_done | clear_status) ? 1'b0 : (rqs_reg | (mss & ~mss_d));

  // enable masks
  logic mask_wr_std, mask_wr_a, mask_wr_b, mask_wr_c, mask_wr_sre, mask_wr_pre;
  assign mask_wr_std = req.wr && req.sel == SER_SEL_STD;
  assign mask_wr_a = req.wr && req.sel == SER_SEL_A;
  assign mask_wr_b = req.wr && req.sel == SER_SEL_B;
  assign mask_wr_c = req.wr && req.sel == SER_SEL_C;
  assign mask_wr_sre = req.wr && req.sel == SER_SEL_SRE;
  assign mask_wr_pre = req.wr && req.sel == SER_SEL_PRE;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      event_mask_a <= SER_RST_MASK;
      event_mask_b <= SER_RST_MASK;
      event_mask_c <= SER_RST_MASK;
    end
    else if (power_off)
    begin
      event_mask_a <= SER_RST_MASK;
      event_mask_b <= SER_RST_MASK;
      event_mask_c <= SER_RST_MASK;
    end
    else
    begin
      if (mask_wr_a) event_mask_a <= req.data;
      if (mask_wr_b) event_mask_b <= req.data;
      if (mask_wr_c) event_mask_c <= req.data;
    end
  end

  // rst models a first power-up; power_off clears std_mask, sre_mask and pre_mask only when flag set
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      std_mask <= SER_RST_MASK;
      sre_mask <= SER_RST_MASK;
      pre_mask <= SER_RST_MASK;
    end
    else if (power_off && psc_flag)
    begin
      std_mask <= SER_RST_MASK;
      sre_mask <= SER_RST_MASK;
      pre_mask <= SER_RST_MASK;
    end
    else
    begin
      if (mask_wr_std) std_mask <= req.data;
      if (mask_wr_sre) sre_mask <= req.data;
      if (mask_wr_pre) pre_mask <= req.data;
    end
  end

  // non-volatile flag: only its own command changes it
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      psc_flag <= SER_RST_PSC;
    else if (psc_wr)
      psc_flag <= psc_val;
  end

  // read mux: events by sel 0-3, masks by sel 0-3 with bit 7 of data set, and by sel 4-5 always
  always_comb
  begin
    rd_next = 8'h00;
    if (stb_query)
      rd_next = stb_next;
    else if (req.rd)
    begin
      unique case (req.sel)
        SER_SEL_STD: rd_next = req.data[7] ? std_mask : std_reg;
        SER_SEL_A: rd_next = req.data[7] ? event_mask_a : event_reg_a;
        SER_SEL_B: rd_next = req.data[7] ? event_mask_b : event_reg_b;
        SER_SEL_C: rd_next = req.data[7] ? event_mask_c : event_reg_c;
        SER_SEL_SRE: rd_next = sre_mask;
        SER_SEL_PRE: rd_next = pre_mask;
        default: rd_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data <= '0;
      condition_reg_a <= '0;
      condition_reg_b <= '0;
      status_byte <= '0;
      poll_byte <= '0;
      rqs_reg <= 1'b0;
      mss_d <= 1'b0;
      service_request <= 1'b0;
      parallel_poll <= 1'b0;
    end
    else
    begin
      rd_data <= rd_next;
      condition_reg_a <= cra_next;
      condition_reg_b <= crb_next;
      status_byte <= stb_next;
      poll_byte <= {1'b0, rqs_next, stb_next[5:0]};
      rqs_reg <= rqs_next;
      mss_d <= mss;
      service_request <= mss;
      parallel_poll <= group_sum(stb_next, pre_mask);
    end
  end

  a_bits_zero: assert property (@(posedge sys_clk) disable iff (rst)
    status_byte[7] == 1'b0 && status_byte[0] == 1'b0) else $error("unused bits set");
  a_srq_follows: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 service_request == |(status_byte[5:1] & $past(sre_mask[5:1]))) else $error("srq differs from mss");
  a_poll_clears: assert property (@(posedge sys_clk) disable iff (rst)
    serial_poll_done |=> !rqs_reg) else $error("rqs not cleared");
  a_clear_events: assert property (@(posedge sys_clk) disable iff (rst)
    clear_status && $past(pin_s2_reg) == pin_s2_reg && $past(pin2_s2_reg) == pin2_s2_reg
    ##1 $stable(pin_s2_reg) && $stable(pin2_s2_reg) |-> std_reg == $past(std_hit)) else $error("clear failed");
  a_mask_off: assert property (@(posedge sys_clk) disable iff (rst)
    power_off |=> event_mask_a == 8'h00 && event_mask_b == 8'h00 && event_mask_c == 8'h00) else $error("mask kept");
  a_mask_keep: assert property (@(posedge sys_clk) disable iff (rst)
    power_off && !psc_flag && !req.wr |=> $stable(sre_mask)) else $error("sre lost");
  a_psc_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !psc_wr |=> $stable(psc_flag)) else $error("psc changed");
  a_mask_write: assert property (@(posedge sys_clk) disable iff (rst)
    mask_wr_sre && !power_off |=> sre_mask == $past(req.data)) else $error("mask write lost");
  a_sum_map: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 status_byte[SER_STB_A] == $past(sum_a)) else $error("summary a wrong");
  c_srq: cover property (@(posedge sys_clk) disable iff (rst) service_request);
  c_poll: cover property (@(posedge sys_clk) disable iff (rst) rqs_reg ##1 serial_poll_done);
  c_clear: cover property (@(posedge sys_clk) disable iff (rst) (|event_reg_a) ##1 clear_status);
  c_poweroff: cover property (@(posedge sys_clk) disable iff (rst) psc_flag && power_off);
endmodule

/* hw/ser_pkg.sv */
package ser_pkg;
  localparam int SER_W = 8;
  localparam logic [2:0] SER_SEL_STD = 3'h0;
  localparam logic [2:0] SER_SEL_A = 3'h1;
  localparam logic [2:0] SER_SEL_B = 3'h2;
  localparam logic [2:0] SER_SEL_C = 3'h3;
  localparam logic [2:0] SER_SEL_SRE = 3'h4;
  localparam logic [2:0] SER_SEL_PRE = 3'h5;
  localparam logic [7:0] SER_RST_MASK = 8'h00;
  localparam logic SER_RST_PSC = 1'b0;
  localparam int SER_STB_A = 1;
  localparam int SER_STB_B = 2;
  localparam int SER_STB_C = 3;
  localparam int SER_STB_MAV = 4;
  localparam int SER_STB_STD = 5;
  localparam int SER_STB_MSS = 6;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] sel;
    logic [7:0] data;
  } ser_req_s;
endpackage

/* hw/ser_edge_reg.sv */
`timescale 1ns/1ps
module ser_edge_reg
  import ser_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] cond,
  input wire logic [W-1:0] rise_en,
  input wire logic [W-1:0] fall_en,
  input wire logic clr,
  output logic [W-1:0] events
);
  logic [W-1:0] cond_reg;
  logic [W-1:0] hit;
  logic [W-1:0] events_next;
  assign hit = (cond & ~cond_reg & rise_en) | (~cond & cond_reg & fall_en);
  // set wins over clear
  assign events_next = (clr ? {W{1'b0}} : events) | hit;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cond_reg <= '0;
      events <= '0;
    end
    else
    begin
      cond_reg <= cond;
      events <= events_next;
    end
  end
  a_edge_sets: assert property (@(posedge sys_clk) disable iff (rst)
    |hit |=> ((events & $past(hit)) == $past(hit))) else $error("edge not latched");
endmodule

/* verification/ser_host_model.sv */
`timescale 1ns/1ps
module ser_host_model
  import ser_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [7:0] rd_data,
  output ser_req_s req,
  output logic clear_status,
  output logic psc_wr,
  output logic psc_val,
  output logic stb_query,
  output logic serial_poll_done,
  output logic power_off
);
  initial
  begin
    req = '0;
    {clear_status, psc_wr, psc_val, stb_query, serial_poll_done, power_off} = 6'h00;
  end
  // one command per call: raised after an edge, taken at the next, answer read after it
  task automatic op(input ser_req_s r, input logic [5:0] ctl, output logic [7:0] q);
    @(posedge sys_clk);
    #2;
    req = r;
    {clear_status, psc_wr, psc_val, stb_query, serial_poll_done, power_off} = ctl;
    @(posedge sys_clk);
    #2;
    req = '0;
    {clear_status, psc_wr, psc_val, stb_query, serial_poll_done, power_off} = 6'h00;
    q = rd_data;
  endtask
endmodule

/* verification/tb.sv */
`timescale 1ns/1ps
module tb
  import ser_pkg::*;
();
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] std_in = 8'h00;
  logic [6:0] pa = 7'h00;
  logic [8:0] pb = 9'h000;
  logic mav_in = 1'b0;
  logic [7:0] rd_data, cond_a, cond_b, stb, poll, q, e;
  logic psc, srq, pp;
  ser_req_s req;
  logic clr, psc_wr, psc_val, stb_q, spd, poff;
  logic [7:0] ev_a = 8'h00, ev_b = 8'h00, ev_s = 8'h00, ca = 8'h00, cb = 8'h00;
  wire [7:0] xa = {pa, |pa[2:0]};
  wire [7:0] xb = {pb[8:6], pb[5] & ~pb[1], pb[4] & ~pb[0], pb[3:2], 1'b0};
  int m[6];
  int errors = 0;
  int samples_checked = 0;
  int seed = 26076;
  int i;
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  ser_host_model h (.sys_clk(sys_clk), .rd_data(rd_data), .req(req), .clear_status(clr), .psc_wr(psc_wr),
    .psc_val(psc_val), .stb_query(stb_q), .serial_poll_done(spd), .power_off(poff));
  ser_status DUT (.sys_clk(sys_clk), .rst(rst), .power_off(poff), .req(req), .clear_status(clr),
    .psc_wr(psc_wr), .psc_val(psc_val), .stb_query(stb_q), .serial_poll_done(spd), .std_events_in(std_in),
    .overvoltage_trip(pa[6]), .power_interrupted(pa[5]), .query_error(pa[4]), .remote_to_local(pa[3]),
    .signal_one_active(pa[2]), .signal_two_active(pa[1]), .signal_three_active(pa[0]),
    .sequence_running(pb[8]), .sequence_done(pb[7]), .sequence_error(pb[6]), .trigger_input_one(pb[5]),
    .trigger_input_two(pb[4]), .trig_one_off(pb[1]), .trig_two_off(pb[0]), .selftest_busy(pb[3]),
    .selftest_error(pb[2]), .output_data_ready(mav_in), .rise_en_a(8'hFF), .fall_en_a(8'h00),
    .rise_en_b(8'hFF), .fall_en_b(8'h00), .rd_data(rd_data), .condition_reg_a(cond_a),
    .condition_reg_b(cond_b), .status_byte(stb), .poll_byte(poll), .psc_flag(psc),
    .service_request(srq), .parallel_poll(pp));
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] got);
    samples_checked++;
    if (got !== x)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, x, got);
    end
  endtask
  task automatic rd(input logic [2:0] s, input logic mk, output logic [7:0] d);
    h.op('{1'b0, 1'b1, s, {mk, 7'h00}}, 6'h00, d);
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    h.op('{1'b1, 1'b0, s, d}, 6'h00, q);
  endtask
  // control bits: clear, flag write, flag value, query, poll done, power off
  task automatic ctl(input logic [5:0] c);
    h.op('0, c, q);
  endtask
  task automatic chk_masks();
    for (int k = 0; k < 6; k++)
    begin
      rd(k[2:0], 1'b1, q);
      chk("mask", m[k][7:0], q);
    end
  endtask
  function automatic logic [7:0] exp_stb();
    logic [7:0] s;
    s = 8'h00;
    s[1] = |(ev_a & m[1][7:0]);
    s[2] = |(ev_b & m[2][7:0]);
    s[4] = mav_in;
    s[5] = |(ev_s & m[0][7:0]);
    s[6] = |(s[5:1] & m[4][5:1]);
    return s;
  endfunction
  task automatic stop_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    stop_test();
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    cyc(2);
    chk("status_byte", 8'h00, stb);
    m = '{8'h04, 8'hFF, 8'hFF, 8'h00, 8'h3E, 8'h00};
    m[5] = $random(seed) & 8'hFF;
    for (i = 0; i < 6; i++) wr(i[2:0], m[i][7:0]);
    repeat (2) chk_masks();
    repeat (4)
    begin
      pa = 7'($random(seed));
      pb = 9'($random(seed));
      cyc(6);
      ev_a = ev_a | (xa & ~ca);
      ev_b = ev_b | (xb & ~cb);
      ca = xa;
      cb = xb;
      chk("condition_reg_a", ca, cond_a);
      chk("condition_reg_b", cb, cond_b);
    end
    std_in = 8'h24;
    cyc(1);
    std_in = 8'h00;
    ev_s = 8'h24;
    mav_in = 1'b1;
    cyc(6);
    e = exp_stb();
    chk("status_byte", e, stb);
    chk("service_request", {7'h00, e[6]}, {7'h00, srq});
    chk("parallel_poll", {7'h00, |(e & m[5][7:0])}, {7'h00, pp});
    chk("poll_byte", e, poll);
    ctl(6'h02);
    cyc(2);
    chk("poll_byte", e & 8'hBF, poll);
    rd(3'h1, 1'b0, q);
    chk("event_reg_a", ev_a, q);
    rd(3'h1, 1'b0, q);
    chk("event_reg_a", 8'h00, q);
    rd(3'h0, 1'b0, q);
    chk("event_std", ev_s, q);
    // buffer-ready rose once, so only the top bit of event c is set
    rd(3'h3, 1'b0, q);
    chk("event_reg_c", 8'h80, q);
    {ev_a, ev_b, ev_s} = 24'h000000;
    ctl(6'h20);
    cyc(3);
    e = exp_stb();
    chk("status_byte", e, stb);
    chk("poll_byte", e & 8'hBF, poll);
    rd(3'h2, 1'b0, q);
    chk("event_reg_b", 8'h00, q);
    ctl(6'h18);
    cyc(1);
    chk("psc_flag", 8'h01, {7'h00, psc});
    ctl(6'h01);
    cyc(1);
    chk("psc_flag", 8'h01, {7'h00, psc});
    m = '{default: 0};
    chk_masks();
    for (i = 0; i < 6; i++)
    begin
      m[i] = $random(seed) & 8'hFF;
      wr(i[2:0], m[i][7:0]);
    end
    ctl(6'h10);
    ctl(6'h20);
    cyc(1);
    chk("psc_flag", 8'h00, {7'h00, psc});
    ctl(6'h01);
    m[1] = 0;
    m[2] = 0;
    m[3] = 0;
    chk_masks();
    stop_test();
  end
endmodule
